// [slr_consts.svh]
// Constants of the serial line-rate configuration block.
// Assumes a 100 MHz sys_clk; included by the package and the modules.
`ifndef SLR_CONSTS_SVH
`define SLR_CONSTS_SVH
`define SLR_NPORT          8
`define SLR_PORT_W         3
`define SLR_CLK_PERIOD_NS  10
`define SLR_HOLD_NS        100
`define SLR_HOLD_CYC \
  ((`SLR_HOLD_NS + `SLR_CLK_PERIOD_NS - 1) / `SLR_CLK_PERIOD_NS)
`define SLR_EE_ADDR_W      8
`define SLR_EE_DATA_W      16
`define SLR_EE_COUNT_ADDR  8'h00
`define SLR_ENT_PORT_HI    10
`define SLR_ENT_PORT_LO    8
`define SLR_ENT_X25_BIT    0
`define SLR_MULT_DEFAULT   1'b0
`endif

// [slr_pkg.sv]
// Types shared by the line-rate configuration modules.
// Needs slr_consts.svh on the include path.
`include "slr_consts.svh"
package slr_pkg;
  typedef enum logic [1:0] {SLR_REF_156M25, SLR_REF_153M6,
                            SLR_REF_125M} slr_ref_e_t;
  typedef enum logic [2:0] {SLR_RATE_NONE, SLR_RATE_1G2288, SLR_RATE_1G25,
                            SLR_RATE_1G536, SLR_RATE_2G4576, SLR_RATE_2G5,
                            SLR_RATE_3G072, SLR_RATE_3G125} slr_rate_e_t;
  typedef enum logic [2:0] {SLR_WAIT_OPT, SLR_RD_COUNT, SLR_RD_ENTRY,
                            SLR_RUN} slr_boot_e_t;
  // One multiplier write: x25 high selects the raised multiplier
  typedef struct packed {
    logic                   valid;
    logic [`SLR_PORT_W-1:0] port;
    logic                   x25;
  } slr_cfg_wr_t;
  typedef struct packed {
    logic                      valid;
    logic [`SLR_EE_DATA_W-1:0] data;
  } slr_ee_rsp_t;
endpackage

// [slr_option_sampler.sv]
// Captures the power-up option pins after hard reset is released.
// Pins are synchronous to sys_clk and held stable for the hold window.
`timescale 1ns/1ns
`include "slr_consts.svh"
module slr_option_sampler (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Option pins
  input  wire logic [1:0] line_rate_select,
  // Captured value
  output logic [1:0]      optCode,
  output logic            optValid
);
  import slr_pkg::*;

  typedef struct packed {
    logic [1:0] first;
    logic [1:0] second;
    logic [3:0] cnt;
    logic [1:0] code;
    logic       valid;
  } slr_samp_t;

  slr_samp_t st, next_st;

  // The code is the pin value sampled at the end of the hold window, so a
  // pin still settling at release never reaches the core
  always_comb begin
    next_st       = st;
    next_st.first = line_rate_select;
    if (!st.valid) begin
      next_st.cnt = st.cnt + 4'h1;
      if (st.cnt == 4'(`SLR_HOLD_CYC - 1)) begin
        next_st.second = line_rate_select;
        next_st.code   = (st.first == line_rate_select) ? st.first
                                                        : line_rate_select;
        next_st.valid  = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign optCode  = st.code;
  assign optValid = st.valid;

  a_hold_window: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(optValid) |-> st.cnt == 4'(`SLR_HOLD_CYC))
    else $error("option capture outside hold window");
endmodule // slr_option_sampler

// [slr_line_rate_config.sv]
// Line-rate selection and volatile SerDes multiplier store, per port.
// Assumes synchronous inputs, one sys_clk, and an EEPROM reader that
// answers one word per request with a valid pulse.
`timescale 1ns/1ns
`include "slr_consts.svh"
module slr_line_rate_config (
  // Clock and hard reset
  input  wire logic                         sys_clk,
  input  wire logic                         arst_n,
  // Board straps and controls
  input  wire logic [1:0]                   line_rate_select,
  input  wire slr_pkg::slr_ref_e_t          refClkSel,
  input  wire logic                         obsaiMode,
  input  wire logic [`SLR_NPORT-1:0]        port_power_down,
  input  wire logic                         eepromPresent,
  // Boot EEPROM reader
  output logic                              eeRdReq,
  output logic [`SLR_EE_ADDR_W-1:0]         eeRdAddr,
  input  wire slr_pkg::slr_ee_rsp_t         eeRsp,
  // Maintenance writes from a host
  input  wire slr_pkg::slr_cfg_wr_t         mntWr,
  // Boundary-scan test port access
  input  wire slr_pkg::slr_cfg_wr_t         tstWr,
  input  wire logic [`SLR_PORT_W-1:0]       tstRdPort,
  output logic                              tstRdX25,
  // SerDes side
  output logic                              serdesResetN,
  output logic [`SLR_NPORT-1:0]             mulX25,
  output slr_pkg::slr_rate_e_t [`SLR_NPORT-1:0] lineRate,
  output logic                              bootDone
);
  import slr_pkg::*;

  typedef struct packed {
    slr_boot_e_t                      fsm;
    logic [`SLR_EE_ADDR_W-1:0]        addr;
    logic [7:0]                       left;
    logic [`SLR_NPORT-1:0]            x25;
    slr_rate_e_t [`SLR_NPORT-1:0]     rate;
    logic                             tstX25;
  } slr_state_t;

  slr_state_t  st, next_st;
  logic [1:0]  optCode;
  logic        optValid;

  slr_option_sampler u_sampler (
    .sys_clk          (sys_clk),
    .arst_n           (arst_n),
    .line_rate_select (line_rate_select),
    .optCode          (optCode),
    .optValid         (optValid)
  );

  // Multiplier bits only matter with the 125 MHz reference and code 1,0;
  // every other rate depends on the reference and the code, and 153.6 MHz code 0,1 also on obsaiMode
  function automatic slr_rate_e_t rateOf(slr_ref_e_t refSel,
                                         logic [1:0] code,
                                         logic x25, logic obsai);
    rateOf = SLR_RATE_NONE;
    unique case (refSel)
      SLR_REF_156M25: begin
        unique case (code)
          2'b00:   rateOf = SLR_RATE_1G25;
          2'b01:   rateOf = SLR_RATE_2G5;
          2'b10:   rateOf = SLR_RATE_3G125;
          default: rateOf = SLR_RATE_NONE;
        endcase
      end
      SLR_REF_153M6: begin
        unique case (code)
          2'b00:   rateOf = SLR_RATE_1G2288;
          2'b01:   rateOf = obsai ? SLR_RATE_1G536 : SLR_RATE_2G4576;
          2'b10:   rateOf = SLR_RATE_3G072;
          default: rateOf = SLR_RATE_NONE;
        endcase
      end
      SLR_REF_125M: begin
        unique case (code)
          2'b01:   rateOf = SLR_RATE_1G25;
          2'b10:   rateOf = x25 ? SLR_RATE_3G125 : SLR_RATE_2G5;
          default: rateOf = SLR_RATE_NONE;
        endcase
      end
      default: rateOf = SLR_RATE_NONE;
    endcase
  endfunction

  always_comb begin
    next_st = st;
    unique case (st.fsm)
      SLR_WAIT_OPT: begin
        if (optValid) begin
          next_st.addr = `SLR_EE_COUNT_ADDR;
          next_st.fsm  = eepromPresent ? SLR_RD_COUNT : SLR_RUN;
        end
      end
      SLR_RD_COUNT: begin
        if (eeRsp.valid) begin
          next_st.left = eeRsp.data[7:0];
          next_st.addr = st.addr + 8'h01;
          next_st.fsm  = (eeRsp.data[7:0] == 8'h00) ? SLR_RUN : SLR_RD_ENTRY;
        end
      end
      SLR_RD_ENTRY: begin
        if (eeRsp.valid) begin
          next_st.x25[eeRsp.data[`SLR_ENT_PORT_HI:`SLR_ENT_PORT_LO]] =
            eeRsp.data[`SLR_ENT_X25_BIT];
          next_st.left = st.left - 8'h01;
          next_st.addr = st.addr + 8'h01;
          if (st.left == 8'h01) begin
            next_st.fsm = SLR_RUN;
          end
        end
      end
      SLR_RUN: begin
        // Host writes only once the links are up
        if (mntWr.valid) begin
          next_st.x25[mntWr.port] = mntWr.x25;
        end
      end
      default: next_st.fsm = SLR_WAIT_OPT;
    endcase
    // Test port reaches the store in any state and wins a collision
    if (tstWr.valid) begin
      next_st.x25[tstWr.port] = tstWr.x25;
    end
    // Power-down overrides every writer so the default is re-applied
    for (int i = 0; i < `SLR_NPORT; i++) begin
      if (port_power_down[i]) begin
        next_st.x25[i] = `SLR_MULT_DEFAULT;
      end
      next_st.rate[i] = optValid
        ? rateOf(refClkSel, optCode, st.x25[i], obsaiMode)
        : SLR_RATE_NONE;
    end
    next_st.tstX25 = st.x25[tstRdPort];
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign eeRdReq      = (st.fsm == SLR_RD_COUNT) || (st.fsm == SLR_RD_ENTRY);
  assign eeRdAddr     = st.addr;
  assign serdesResetN = (st.fsm == SLR_RUN);
  assign bootDone     = (st.fsm == SLR_RUN);
  assign mulX25       = st.x25;
  assign lineRate     = st.rate;
  assign tstRdX25     = st.tstX25;

  sequence s_last_entry;
    st.fsm == SLR_RD_ENTRY && eeRsp.valid && st.left == 8'h01;
  endsequence

  sequence s_release;
    ##1 serdesResetN;
  endsequence

  a_boot_release: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    s_last_entry |-> s_release)
    else $error("SerDes not released after last boot entry");

  a_no_early_rel: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(serdesResetN) |-> !$past(eeRdReq) || st.left == 8'h00)
    else $error("SerDes released with boot entries pending");

  a_count_load: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    st.fsm == SLR_RD_COUNT && eeRsp.valid && eeRdAddr == 8'h00
    |=> st.left == $past(eeRsp.data[7:0]))
    else $error("entry count not taken from first word");

  a_req_hold: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    eeRdReq && !eeRsp.valid |=> eeRdReq && $stable(eeRdAddr))
    else $error("boot word request dropped before its answer");

  a_addr_step: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    eeRdReq && eeRsp.valid |=> eeRdAddr == $past(eeRdAddr) + 8'h01)
    else $error("boot word address did not advance");

  a_pdown_default: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    port_power_down != '0 |=> (mulX25 & $past(port_power_down)) == '0)
    else $error("power-down did not restore default multiplier");

  a_mnt_refused: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !bootDone && mntWr.valid && !tstWr.valid && !eeRsp.valid
    && port_power_down == '0 |=> $stable(mulX25))
    else $error("host write taken before boot finished");

  a_rate_156: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    optValid && refClkSel == SLR_REF_156M25 && optCode == 2'b10
    |=> lineRate[0] == SLR_RATE_3G125)
    else $error("156.25 MHz code 1,0 not 3.125 Gbaud");

  a_rate_153: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    optValid && refClkSel == SLR_REF_153M6 && optCode == 2'b00
    |=> lineRate[1] == SLR_RATE_1G2288)
    else $error("153.6 MHz code 0,0 not 1.2288 Gbaud");

  a_rate_125_x20: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    optValid && refClkSel == SLR_REF_125M && optCode == 2'b10 && !mulX25[2]
    |=> lineRate[2] == SLR_RATE_2G5)
    else $error("125 MHz x20 code 1,0 not 2.5 Gbaud");

  a_rate_125_x25: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    bootDone && refClkSel == SLR_REF_125M && optCode == 2'b10 && mulX25[3]
    |=> lineRate[3] == SLR_RATE_3G125)
    else $error("x25 port not at 3.125 Gbaud");

  a_test_write: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    tstWr.valid && !port_power_down[tstWr.port]
    |=> mulX25[$past(tstWr.port)] == $past(tstWr.x25))
    else $error("test port write not stored");

  a_test_read: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    1'b1 |=> tstRdX25 == $past(mulX25[tstRdPort]))
    else $error("test port read wrong");

  // Writers are excluded so that only the reference changes that cycle
  a_same_setting: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $changed(refClkSel) && !tstWr.valid && !mntWr.valid && !eeRsp.valid
    && port_power_down == '0 |=> $stable(mulX25))
    else $error("multiplier changed with reference");
endmodule // slr_line_rate_config

// [slr_ee_model.sv]
// Boot EEPROM stand-in: answers each word request lat plus one cycles after it is raised.
// Assumes the requester holds eeRdReq and eeRdAddr until the answer.
`timescale 1ns/1ns
`include "slr_consts.svh"
module slr_ee_model (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  // Word request and answer
  input  wire logic                      eeRdReq,
  input  wire logic [`SLR_EE_ADDR_W-1:0] eeRdAddr,
  input  wire logic [3:0]                lat,
  output slr_pkg::slr_ee_rsp_t           eeRsp
);
  import slr_pkg::*;
  logic [`SLR_EE_DATA_W-1:0] mem [0:255];
  logic [3:0]                cnt;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt   <= 4'h0;
      eeRsp <= '0;
    end else begin
      eeRsp.valid <= 1'b0;
      // Stale data flips each cycle so no one can lean on it
      eeRsp.data  <= ~eeRsp.data;
      if (eeRdReq && !eeRsp.valid) begin
        if (cnt == lat) begin
          eeRsp <= {1'b1, mem[eeRdAddr]};
          cnt   <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule // slr_ee_model

// [slr_line_rate_config_tb.sv]
// Self-checking bench for the line-rate configuration block.
// EEPROM stand-in on the boot port; host and test writes from tasks.
`timescale 1ns/1ns
`include "slr_consts.svh"
module slr_line_rate_config_tb;
  import slr_pkg::*;
  logic                         sys_clk;
  logic                         arst_n;
  logic [1:0]                   line_rate_select;
  slr_ref_e_t                   refClkSel;
  logic                         obsaiMode;
  logic [`SLR_NPORT-1:0]        port_power_down;
  logic                         eepromPresent;
  logic                         eeRdReq;
  logic [`SLR_EE_ADDR_W-1:0]    eeRdAddr;
  slr_ee_rsp_t                  eeRsp;
  slr_cfg_wr_t                  mntWr;
  slr_cfg_wr_t                  tstWr;
  logic [`SLR_PORT_W-1:0]       tstRdPort;
  logic                         tstRdX25;
  logic                         serdesResetN;
  logic [`SLR_NPORT-1:0]        mulX25;
  slr_rate_e_t [`SLR_NPORT-1:0] lineRate;
  logic                         bootDone;
  logic [3:0]                   lat;
  int                           nFail;
  int                           checks;
  slr_line_rate_config u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .line_rate_select(line_rate_select), .refClkSel(refClkSel),
    .obsaiMode(obsaiMode), .port_power_down(port_power_down),
    .eepromPresent(eepromPresent), .eeRdReq(eeRdReq),
    .eeRdAddr(eeRdAddr), .eeRsp(eeRsp), .mntWr(mntWr), .tstWr(tstWr),
    .tstRdPort(tstRdPort), .tstRdX25(tstRdX25),
    .serdesResetN(serdesResetN), .mulX25(mulX25), .lineRate(lineRate),
    .bootDone(bootDone));
  slr_ee_model u_ee (.sys_clk(sys_clk), .arst_n(arst_n), .eeRdReq(eeRdReq),
    .eeRdAddr(eeRdAddr), .lat(lat), .eeRsp(eeRsp));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Pins stay put until the next reset, well past the hold window
  task automatic hardReset(input logic [1:0] code, input int expCyc);
    arst_n = 1'b0;
    line_rate_select = code;
    step(4);
    arst_n = 1'b1;
    for (int i = 0; i < expCyc; i++) begin
      chk({15'h0, serdesResetN}, 16'h0);
      step(1);
    end
    chk({14'h0, serdesResetN, bootDone}, 16'h3);
  endtask
  function automatic slr_rate_e_t expRate(logic [3:0] rc, logic x, logic o);
    case (rc)
      4'h0: return SLR_RATE_1G25;
      4'h1: return SLR_RATE_2G5;
      4'h2: return SLR_RATE_3G125;
      4'h4: return SLR_RATE_1G2288;
      4'h5: return o ? SLR_RATE_1G536 : SLR_RATE_2G4576;
      4'h6: return SLR_RATE_3G072;
      4'h9: return SLR_RATE_1G25;
      4'ha: return x ? SLR_RATE_3G125 : SLR_RATE_2G5;
      default: return SLR_RATE_NONE;
    endcase
  endfunction
  task automatic chkRates(input logic [1:0] r, input logic [1:0] c,
                          input logic [7:0] x);
    for (int p = 0; p < `SLR_NPORT; p++)
      chk(16'(lineRate[p]), 16'(expRate({r, c}, x[p], obsaiMode)));
  endtask
  task automatic drive(input slr_cfg_wr_t m, input slr_cfg_wr_t t);
    mntWr = m;
    tstWr = t;
    step(1);
  endtask
  task automatic t_rates;
    eepromPresent = 1'b0;
    for (int r = 0; r < 3; r++)
      for (int c = 0; c < 4; c++)
        for (int o = 0; o < 2; o++) begin
          refClkSel = slr_ref_e_t'(r);
          obsaiMode = o[0];
          hardReset(c[1:0], `SLR_HOLD_CYC + 1);
          step(2);
          chkRates(r[1:0], c[1:0], 8'h00);
        end
    $display("test rates done");
  endtask
  task automatic t_boot(input logic [3:0] l);
    lat = l;
    eepromPresent = 1'b1;
    refClkSel = SLR_REF_125M;
    // A host write held across boot must be ignored until the links run
    mntWr = '{1'b1, 3'h0, 1'b1};
    // Leave wait, then count word and two entries of lat plus two cycles
    hardReset(2'h2, `SLR_HOLD_CYC + 7 + 3 * l);
    chk(16'(mulX25), 16'h0028);
    mntWr = '0;
    step(2);
    chkRates(2'h2, 2'h2, 8'h28);
    $display("test boot done");
  endtask
  task automatic t_writes;
    drive('{1'b1, 3'h1, 1'b1}, '0);
    chk({15'h0, mulX25[1]}, 16'h1);
    drive('{1'b1, 3'h6, 1'b1}, '{1'b1, 3'h6, 1'b0});
    chk({15'h0, mulX25[6]}, 16'h0);
    drive('{1'b1, 3'h7, 1'b1}, '{1'b1, 3'h5, 1'b0});
    drive('0, '0);
    chk(16'(mulX25), 16'h008a);
    chkRates(2'h2, 2'h2, 8'h8a);
    tstRdPort = 3'h3;
    step(1);
    chk({15'h0, tstRdX25}, 16'h1);
    port_power_down = 8'h08;
    drive('{1'b1, 3'h3, 1'b1}, '0);
    chk(16'(mulX25), 16'h0082);
    port_power_down = 8'h00;
    drive('0, '0);
    // Reference swapped live: multipliers stay, rates follow the reference
    refClkSel = SLR_REF_156M25;
    step(2);
    chk(16'(mulX25), 16'h0082);
    chkRates(2'h0, 2'h2, 8'h82);
    arst_n = 1'b0;
    step(1);
    chk(16'(mulX25), 16'h0000);
    $display("test writes done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    nFail++;
    summarize();
  end
  initial begin
    nFail = 0;
    checks = 0;
    arst_n = 1'b0;
    line_rate_select = 2'h0;
    refClkSel = SLR_REF_156M25;
    obsaiMode = 1'b0;
    port_power_down = 8'h00;
    eepromPresent = 1'b0;
    mntWr = '0;
    tstWr = '0;
    tstRdPort = 3'h0;
    lat = 4'h0;
    u_ee.mem[0] = 16'h0002;
    u_ee.mem[1] = 16'hf301;
    u_ee.mem[2] = 16'h7d01;
    u_ee.mem[3] = 16'h0701;
    t_rates();
    t_boot(4'h0);
    t_boot(4'h5);
    t_writes();
    summarize();
  end
endmodule // slr_line_rate_config_tb
